// ===== pcm_pkg.sv
package pcm_pkg;

    // pin indices inside the two-pin group
    localparam int PCM_PIN_N = 2;
    localparam int PCM_XIN_IDX = 0;
    localparam int PCM_CRYSTAL_OUTPUT_IDX = 1;

    // register byte offsets, one aligned word each
    localparam logic [7:0] PCM_OFS_SEL = 8'h00;
    localparam logic [7:0] PCM_OFS_DIR = 8'h04;
    localparam logic [7:0] PCM_OFS_OUT = 8'h08;
    localparam logic [7:0] PCM_OFS_ADIS = 8'h0C;
    localparam logic [7:0] PCM_OFS_CMP = 8'h10;
    localparam logic [7:0] PCM_OFS_IN = 8'h14;
    localparam logic [7:0] PCM_OFS_STAT = 8'h18;

    // reset values
    localparam logic [1:0] PCM_SEL_RST = 2'h3;
    localparam logic [1:0] PCM_DIR_RST = 2'h0;
    localparam logic [1:0] PCM_OUT_RST = 2'h0;
    localparam logic [1:0] PCM_ADIS_RST = 2'h0;
    localparam logic [2:0] PCM_CMP_RST = 3'h0;

    // comparator channel codes, bit3 bit2 bit1
    localparam logic [2:0] PCM_CMP_CH6 = 3'h6;
    localparam logic [2:0] PCM_CMP_CH7 = 3'h7;

    // status word: 4 bits per pin, mode [1:0], driver on [2], input buffer on [3]
    localparam int PCM_STAT_W = 4;
    localparam int PCM_STAT_DRV_BIT = 2;
    localparam int PCM_STAT_IBUF_BIT = 3;

    typedef enum logic [1:0] {
        PCM_MODE_GPIO_IN = 2'b00,
        PCM_MODE_GPIO_OUT = 2'b01,
        PCM_MODE_XTAL = 2'b10,
        PCM_MODE_ANALOG = 2'b11
    } pcm_mode_type;

endpackage : pcm_pkg

// ===== pcm_pin_cell.sv
`timescale 1ns/10ps
module pcm_pin_cell
    import pcm_pkg::*;
#(
    parameter bit IS_CRYSTAL_OUTPUT = 1'b0
)
(
    // control bits
    input wire logic func_sel_i,
    input wire logic dir_i,
    input wire logic out_val_i,
    input wire logic adis_i,
    input wire logic cmp_pick_i,
    // oscillator and pad
    input wire logic osc_drive_i,
    input wire logic pad_sync_i,
    // results
    output logic pad_o,
    output logic pad_oe_o,
    output logic in_buf_en_o,
    output logic rd_val_o,
    output logic xtal_en_o,
    output pcm_mode_type mode_o
);

    wire is_analog = adis_i;
    wire is_xtal = ~adis_i & func_sel_i;
    wire is_gpio = ~adis_i & ~func_sel_i;
    // the oscillator drives only the crystal-output pin
    wire xtal_drive = is_xtal & IS_CRYSTAL_OUTPUT;

    // analog-disable overrides select and direction
    assign mode_o = is_analog ? PCM_MODE_ANALOG :    // see [RULE3] see [RULE4]
                    is_xtal ? PCM_MODE_XTAL :
                    dir_i ? PCM_MODE_GPIO_OUT : PCM_MODE_GPIO_IN;

    // driver is off in analog mode to avoid cross currents
    assign pad_oe_o = (is_gpio & dir_i) | xtal_drive;    // see [RULE1] see [RULE4]
    assign pad_o = xtal_drive ? osc_drive_i : (is_gpio & dir_i & out_val_i);

    // schmitt input off for analog, crystal and comparator use
    assign in_buf_en_o = is_gpio & ~cmp_pick_i;    // see [RULE1] see [RULE2]
    assign rd_val_o = pad_sync_i & in_buf_en_o;
    assign xtal_en_o = is_xtal;    // see [RULE3] see [RULE4]

endmodule : pcm_pin_cell

// ===== pcm_crystal_pin_mux.sv
// How it works
// [RULE1] Setting a pin's analog-disable bit turns off both its output driver and its schmitt input.
// [RULE2] A pin picked by the comparator channel code has its digital input buffer off regardless of analog-disable.
// [RULE3] The crystal-input pin is gpio with select 0, crystal input with select 1, analog when analog-disable is 1.
// [RULE4] The crystal-output pin is gpio with select 0, crystal output with select 1, analog when analog-disable is 1.
// [RULE5] After reset both pins come up in their crystal functions.
// [RULE6] Channel code 1,1,0 routes the crystal-input pin to the comparator as channel six.
// [RULE7] Channel code 1,1,1 routes the crystal-output pin to the comparator as channel seven.
// [RULE8] Software using the crystal-output pin as an input must clear its select bit early, as the oscillator drives it.
`timescale 1ns/10ps
module pcm_crystal_pin_mux
    import pcm_pkg::*;
#(
    parameter int WB_ADDR_W = 8,
    parameter int WB_DATA_W = 32
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,

    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADDR_W-1:0] wb_adr_i,
    input wire logic [WB_DATA_W/8-1:0] wb_sel_i,
    input wire logic [WB_DATA_W-1:0] wb_dat_i,
    output logic [WB_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,

    // pads, index 0 crystal-input pin, index 1 crystal-output pin
    input wire logic [PCM_PIN_N-1:0] pad_i,
    output logic [PCM_PIN_N-1:0] pad_o,
    output logic [PCM_PIN_N-1:0] pad_oe_o,

    // oscillator
    input wire logic osc_drive_i,
    output logic crystal_input_en_o,
    output logic crystal_output_en_o,

    // comparator routing
    output logic comparator_channel_six_o,
    output logic comparator_channel_seven_o
);

    if (WB_DATA_W != 32)
    begin : g_chk_data
        $error("pcm_crystal_pin_mux supports 32-bit data only");
    end
    if (WB_ADDR_W < 5 || WB_ADDR_W > 8)
    begin : g_chk_addr
        $error("pcm_crystal_pin_mux needs an address width of 5 to 8");
    end

    // control registers
    logic [PCM_PIN_N-1:0] port_two_function_select_ff;
    logic [PCM_PIN_N-1:0] port_two_direction_ff;
    logic [PCM_PIN_N-1:0] port_out_ff;
    logic [PCM_PIN_N-1:0] analog_input_disable_ff;
    logic [2:0] comparator_channel_select_ff;
    logic [PCM_PIN_N-1:0] pad_meta_ff;
    logic [PCM_PIN_N-1:0] pad_sync_ff;
    logic ack_ff;
    logic [WB_DATA_W-1:0] dat_ff;

    // per-pin results
    logic [PCM_PIN_N-1:0] cmp_pick;
    logic [PCM_PIN_N-1:0] in_buf_en;
    logic [PCM_PIN_N-1:0] rd_val;
    logic [PCM_PIN_N-1:0] xtal_en;
    pcm_mode_type pin_mode [PCM_PIN_N];
    logic [PCM_STAT_W*PCM_PIN_N-1:0] stat_word;

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire [7:0] bus_ofs = 8'(wb_adr_i);
    // a write lands on the edge where the master sees ack
    wire wr_en = bus_req & wb_we_i & ack_ff & wb_sel_i[0];
    wire nxt_ack = bus_req & ~ack_ff;
    wire hit_sel = bus_ofs == PCM_OFS_SEL;
    wire hit_dir = bus_ofs == PCM_OFS_DIR;
    wire hit_out = bus_ofs == PCM_OFS_OUT;
    wire hit_adis = bus_ofs == PCM_OFS_ADIS;
    wire hit_cmp = bus_ofs == PCM_OFS_CMP;
    wire hit_in = bus_ofs == PCM_OFS_IN;
    wire hit_stat = bus_ofs == PCM_OFS_STAT;

    // unmapped offsets read as zero and ignore writes
    wire [WB_DATA_W-1:0] nxt_dat =
        hit_sel ? WB_DATA_W'(port_two_function_select_ff) :
        hit_dir ? WB_DATA_W'(port_two_direction_ff) :
        hit_out ? WB_DATA_W'(port_out_ff) :
        hit_adis ? WB_DATA_W'(analog_input_disable_ff) :
        hit_cmp ? WB_DATA_W'(comparator_channel_select_ff) :
        hit_in ? WB_DATA_W'(rd_val) :
        hit_stat ? WB_DATA_W'(stat_word) : 32'h0000_0000;

    // comparator channel decode
    assign cmp_pick[PCM_XIN_IDX] = comparator_channel_select_ff == PCM_CMP_CH6;    // see [RULE6]
    assign cmp_pick[PCM_CRYSTAL_OUTPUT_IDX] = comparator_channel_select_ff == PCM_CMP_CH7;    // see [RULE7]

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= nxt_ack;
            if (nxt_ack)
            begin
                dat_ff <= nxt_dat;
            end
        end
    end

    // per-register write strobes keep each register process short
    wire wr_sel = wr_en & hit_sel;
    wire wr_dir = wr_en & hit_dir;
    wire wr_out = wr_en & hit_out;
    wire wr_adis = wr_en & hit_adis;
    wire wr_cmp = wr_en & hit_cmp;

    // oscillator functions are the reset default, so the output pin is driven until software clears it
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            port_two_function_select_ff <= PCM_SEL_RST;    // see [RULE5] see [RULE8]
        end
        else if (wr_sel)
        begin
            port_two_function_select_ff <= wb_dat_i[PCM_PIN_N-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            port_two_direction_ff <= PCM_DIR_RST;
        end
        else if (wr_dir)
        begin
            port_two_direction_ff <= wb_dat_i[PCM_PIN_N-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            port_out_ff <= PCM_OUT_RST;
        end
        else if (wr_out)
        begin
            port_out_ff <= wb_dat_i[PCM_PIN_N-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            analog_input_disable_ff <= PCM_ADIS_RST;
        end
        else if (wr_adis)
        begin
            analog_input_disable_ff <= wb_dat_i[PCM_PIN_N-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            comparator_channel_select_ff <= PCM_CMP_RST;
        end
        else if (wr_cmp)
        begin
            comparator_channel_select_ff <= wb_dat_i[2:0];
        end
    end

    // pad inputs come from outside the clock domain
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pad_meta_ff <= 2'h0;
            pad_sync_ff <= 2'h0;
        end
        else
        begin
            pad_meta_ff <= pad_i;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    for (genvar p = 0; p < PCM_PIN_N; p++)
    begin : g_pin
        pcm_pin_cell #(
            .IS_CRYSTAL_OUTPUT(p == PCM_CRYSTAL_OUTPUT_IDX)
        ) u_cell (
            .func_sel_i(port_two_function_select_ff[p]),
            .dir_i(port_two_direction_ff[p]),
            .out_val_i(port_out_ff[p]),
            .adis_i(analog_input_disable_ff[p]),
            .cmp_pick_i(cmp_pick[p]),
            .osc_drive_i(osc_drive_i),
            .pad_sync_i(pad_sync_ff[p]),
            .pad_o(pad_o[p]),
            .pad_oe_o(pad_oe_o[p]),
            .in_buf_en_o(in_buf_en[p]),
            .rd_val_o(rd_val[p]),
            .xtal_en_o(xtal_en[p]),
            .mode_o(pin_mode[p])
        );
        assign stat_word[p*PCM_STAT_W +: PCM_STAT_W] = {in_buf_en[p], pad_oe_o[p], pin_mode[p]};
    end

    // pad drive is combinational so the oscillator signal is not resampled at 25 MHz
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign crystal_input_en_o = xtal_en[PCM_XIN_IDX];    // see [RULE3]
    assign crystal_output_en_o = xtal_en[PCM_CRYSTAL_OUTPUT_IDX];    // see [RULE4]
    assign comparator_channel_six_o = cmp_pick[PCM_XIN_IDX];    // see [RULE6]
    assign comparator_channel_seven_o = cmp_pick[PCM_CRYSTAL_OUTPUT_IDX];    // see [RULE7]

endmodule : pcm_crystal_pin_mux

// ===== pcm_crystal_pin_mux_assertions.sv
`timescale 1ns/10ps
module pcm_crystal_pin_mux_assertions
    import pcm_pkg::*;
#(
    parameter int WB_ADDR_W = 8,
    parameter int WB_DATA_W = 32
)
(
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADDR_W-1:0] wb_adr_i,
    input wire logic [WB_DATA_W/8-1:0] wb_sel_i,
    input wire logic [WB_DATA_W-1:0] wb_dat_i,
    input wire logic wb_ack_o,
    // pins and routing
    input wire logic [PCM_PIN_N-1:0] pad_o,
    input wire logic [PCM_PIN_N-1:0] pad_oe_o,
    input wire logic osc_drive_i,
    input wire logic crystal_input_en_o,
    input wire logic crystal_output_en_o,
    input wire logic comparator_channel_six_o,
    input wire logic comparator_channel_seven_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // a write lands at the ack edge
    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");
    property p_rst_xtal; $rose(rst_n_i) |-> crystal_input_en_o && crystal_output_en_o; endproperty
    a_rst_xtal: assert property (p_rst_xtal) else $error("not crystal after reset");
    property p_xin_drv; crystal_input_en_o |-> !pad_oe_o[0]; endproperty
    a_xin_drv: assert property (p_xin_drv) else $error("xin pin driven");
    property p_crystal_output_drv; crystal_output_en_o |-> pad_oe_o[1] && pad_o[1] == osc_drive_i; endproperty
    a_crystal_output_drv: assert property (p_crystal_output_drv) else $error("crystal_output not oscillator");
    property p_adis; wr && wb_adr_i == PCM_OFS_ADIS && wb_dat_i[1] |=> !pad_oe_o[1] && !crystal_output_en_o; endproperty
    a_adis: assert property (p_adis) else $error("analog pin driven");
    property p_six; wr && wb_adr_i == PCM_OFS_CMP && wb_dat_i[2:0] == 3'h6 |=> comparator_channel_six_o; endproperty
    a_six: assert property (p_six) else $error("channel six missing");
    property p_seven; wr && wb_adr_i == PCM_OFS_CMP && wb_dat_i[2:0] == 3'h7 |=> comparator_channel_seven_o; endproperty
    a_seven: assert property (p_seven) else $error("channel seven missing");
    property p_excl; !(comparator_channel_six_o && comparator_channel_seven_o); endproperty
    a_excl: assert property (p_excl) else $error("both channels");
    c_six: cover property (comparator_channel_six_o);
    c_seven: cover property (comparator_channel_seven_o);
    c_adis: cover property (wr && wb_adr_i == PCM_OFS_ADIS);
endmodule : pcm_crystal_pin_mux_assertions

bind pcm_crystal_pin_mux pcm_crystal_pin_mux_assertions #(.WB_ADDR_W(WB_ADDR_W), .WB_DATA_W(WB_DATA_W)) u_chk (
    .clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .pad_o,
    .pad_oe_o, .osc_drive_i, .crystal_input_en_o, .crystal_output_en_o, .comparator_channel_six_o,
    .comparator_channel_seven_o);

// ===== pcm_xtal_src.sv
`timescale 1ns/10ps
module pcm_xtal_src
    import pcm_pkg::*;
(
    // clock and outside levels
    input wire logic clk_i,
    input wire logic [PCM_PIN_N-1:0] lvl_i,
    // device pads
    input wire logic [PCM_PIN_N-1:0] pad_o_i,
    input wire logic [PCM_PIN_N-1:0] pad_oe_i,
    output logic [PCM_PIN_N-1:0] pad_o,
    output logic osc_o
);
    logic osc_ff = 1'b0;
    // free-running amplifier, toggles so a stuck pad is seen
    always @(posedge clk_i) osc_ff <= !osc_ff;
    assign osc_o = osc_ff;
    // the device driver wins the wire while enabled, as the crystal_output pin does until select clears
    assign pad_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & lvl_i);
endmodule : pcm_xtal_src

// ===== pcm_crystal_pin_mux_tb.sv
`timescale 1ns/10ps
module pcm_crystal_pin_mux_tb;
    import pcm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, osc, six, seven, xin_en, crystal_output_en;
    logic [1:0] lvl = 2'h0;
    logic [1:0] pad_i, pad_o, pad_oe_o;
    logic [7:0] zr [5] = '{PCM_OFS_DIR, PCM_OFS_OUT, PCM_OFS_ADIS, PCM_OFS_CMP, 8'h1C};
    logic [2:0] cc [3] = '{3'h6, 3'h7, 3'h5};
    int err_total = 0;
    int compares = 0;
    always #20 clk_i = ~clk_i;
    pcm_crystal_pin_mux dut (.clk_i, .rst_n_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .pad_i, .pad_o, .pad_oe_o, .osc_drive_i(osc),
        .crystal_input_en_o(xin_en), .crystal_output_en_o(crystal_output_en), .comparator_channel_six_o(six),
        .comparator_channel_seven_o(seven));
    pcm_xtal_src u_src (.clk_i, .lvl_i(lvl), .pad_o_i(pad_o), .pad_oe_i(pad_oe_o), .pad_o(pad_i), .osc_o(osc));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        req <= 1'b0;
        #1;
    endtask : xfer
    task rd(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, 4'hF);
        chk(n, rdat, e);
    endtask : rd
    task final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("xin_en", 32'(xin_en), 32'h1);
        chk("crystal_output_en", 32'(crystal_output_en), 32'h1);
        chk("oe_rst", 32'(pad_oe_o), 32'h2);
        chk("osc_pad", 32'(pad_o[1]), 32'(osc));
        rd("sel_rst", PCM_OFS_SEL, 32'h3);
        foreach (zr[i]) rd("zero_rst", zr[i], 32'h0);
        rd("stat_rst", PCM_OFS_STAT, 32'h0000_0062);
        lvl <= 2'b10;
        xfer(1'b1, PCM_OFS_SEL, 32'hFFFF_FFFC, 4'h1);
        chk("xin_off", 32'(xin_en | crystal_output_en), 32'h0);
        repeat (2) @(posedge clk_i);
        rd("in_gpio", PCM_OFS_IN, 32'h2);
        rd("stat_gpio", PCM_OFS_STAT, 32'h0000_0088);
        xfer(1'b1, PCM_OFS_DIR, 32'h1, 4'hF);
        xfer(1'b1, PCM_OFS_OUT, 32'h1, 4'hF);
        chk("out_pin", 32'({pad_oe_o, pad_o[0]}), 32'h3);
        xfer(1'b1, PCM_OFS_ADIS, 32'h3, 4'hF);
        chk("adis_oe", 32'(pad_oe_o), 32'h0);
        rd("adis_in", PCM_OFS_IN, 32'h0);
        rd("adis_stat", PCM_OFS_STAT, 32'h0000_0033);
        xfer(1'b1, PCM_OFS_ADIS, 32'h0, 4'hF);
        xfer(1'b1, PCM_OFS_DIR, 32'h0, 4'hF);
        lvl <= 2'b11;
        foreach (cc[i])
        begin
            xfer(1'b1, PCM_OFS_CMP, 32'(cc[i]), 4'hF);
            chk("ch_six", 32'(six), 32'(cc[i] == 3'h6));
            chk("ch_seven", 32'(seven), 32'(cc[i] == 3'h7));
            repeat (2) @(posedge clk_i);
            rd("cmp_in", PCM_OFS_IN, 32'({cc[i] != 3'h7, cc[i] != 3'h6}));
        end
        xfer(1'b1, PCM_OFS_DIR, 32'h3, 4'h0);
        rd("dir_nosel", PCM_OFS_DIR, 32'h0);
        // a second reset in mid-run must bring the crystal functions back
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("xin_en_rst2", 32'(xin_en), 32'h1);
        chk("crystal_output_en_rst2", 32'(crystal_output_en), 32'h1);
        rd("sel_rst2", PCM_OFS_SEL, 32'h3);
        rd("cmp_rst2", PCM_OFS_CMP, 32'h0);
        xfer(1'b1, PCM_OFS_DIR, 32'h3, 4'hF);
        xfer(1'b1, PCM_OFS_SEL, 32'h3, 4'hF);
        chk("xtal_dir", 32'({pad_oe_o, xin_en, crystal_output_en}), 32'hB);
        final_report();
    end
    initial
    begin
        #400000;
        err_total++;
        final_report();
    end
endmodule : pcm_crystal_pin_mux_tb
